// ### hw/pmrs_top.sv
`timescale 1ns/1ns
// Function
// - Run mode: core, memory, peripheral clocks on
// - Wait instruction: core/memory off, peripherals on
// - Wait exits on interrupt, debug or reset
// - Stop instruction: system clock generation disabled
// - Stop exits on wake interrupt, low-voltage, debug
// - Per-peripheral stop disable keeps its clock
// - Standby runs slow, no triple-rate clock
// - Power-down stops all; only external/power-on exit
// - Peripherals on system clock, some triple-rate
// - Watchdog clock is oscillator divided by 1024
// - Five reset sources, two async, three sync
// - Test port reset only by power-on
// - Extended power-on release 64 oscillator cycles
// - Clock-generator release 32 oscillator cycles later
// - Peripheral release 32 system cycles later
// - Core release 32 system cycles later
// - Early delay counters count oscillator clock
// - Combined reset holds all resets but extender and test port
// - Software/watchdog logic released three cycles later
// - Staged resets released on falling clock edge
module pmrs_top
	import pmrs_pkg::*;
#(
	parameter int NPERIPH = 8
) (
	// Oscillator clock and power-on reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Reset sources
	input wire logic ext_reset_n_i,
	input wire logic watchdog_timeout_reset_i,
	input wire logic watchdog_lost_reference_reset_i,
	// Core and interrupt events
	input wire logic core_wait_i,
	input wire logic core_stop_i,
	input wire logic debug_entry_i,
	input wire logic any_irq_i,
	input wire logic low_voltage_irq_i,
	input wire logic [NPERIPH-1:0] periph_irq_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Clock gating
	output logic sys_tick_o,
	output logic watchdog_tick_o,
	output logic sysclk_gen_en_o,
	output logic core_clk_en_o,
	output logic mem_clk_en_o,
	output logic [NPERIPH-1:0] periph_clk_en_o,
	output logic [PMRS_FAST_W-1:0] fast_clk_en_o,
	// Clock generation module controls
	output logic clock_source_select_o,
	output logic pll_power_down_o,
	output logic relax_osc_standby_o,
	output logic large_regulator_standby_o,
	output logic relax_osc_power_down_o,
	// Internal resets, active low
	output logic tap_reset_n_o,
	output logic ext_por_reset_n_o,
	output logic sync_reset_n_o,
	output logic clock_generator_reset_n_o,
	output logic peripheral_reset_n_o,
	output logic core_reset_n_o
);

	// ==========================================================
	// Reset source synchronisers

	logic rst_any_n;
	logic [2:0] por_sync;
	logic [2:0] ext_sync;
	logic por_ok;
	logic ext_ok;

	// Either async source asserts at once
	assign rst_any_n = reset_n_i & ext_reset_n_i;

	// Power-on release, three stages
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			por_sync <= 3'h0;
		end else begin
			por_sync <= {por_sync[1:0], 1'b1};
		end
	end

	// External pin release, three stages
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			ext_sync <= 3'h0;
		end else begin
			ext_sync <= {ext_sync[1:0], 1'b1};
		end
	end

	// Release counts once the last two stages agree
	assign por_ok = por_sync[1] & por_sync[2];
	assign ext_ok = ext_sync[1] & ext_sync[2];

	// ==========================================================
	// Reset release stages

	logic [PMRS_STAGES-1:0] hold_v;
	logic [PMRS_STAGES-1:0] tick_v;
	logic [PMRS_STAGES-1:0] done_v;
	logic combined_n;
	logic sw_req;
	logic wd_req;
	logic sys_tick;
	pmrs_mode_e mode;

	localparam int DLY_COUNT [PMRS_STAGES] = '{PMRS_XPOR_CYC,
		PMRS_SYNC_CYC, PMRS_CGEN_CYC, PMRS_PERI_CYC, PMRS_CORE_CYC};

	// OR of extended power-on, external, software, watchdog
	assign combined_n = ext_por_reset_n_o & ext_ok & !sw_req &
		!wd_req;

	// Hold and time base of each stage
	always_comb begin
		hold_v[PMRS_ST_XPOR] = !por_ok;
		hold_v[PMRS_ST_SYNC] = !combined_n;
		hold_v[PMRS_ST_CGEN] = !combined_n;
		hold_v[PMRS_ST_PERI] = !done_v[PMRS_ST_CGEN];
		hold_v[PMRS_ST_CORE] = !done_v[PMRS_ST_PERI];
		tick_v[PMRS_ST_XPOR] = 1'b1;
		tick_v[PMRS_ST_SYNC] = 1'b1;
		tick_v[PMRS_ST_CGEN] = 1'b1;
		tick_v[PMRS_ST_PERI] = sys_tick;
		tick_v[PMRS_ST_CORE] = sys_tick;
	end

	// One delay counter per stage; extender sees power-on only
	for (genvar g = 0; g < PMRS_STAGES; g++) begin : g_stage
		pmrs_dly_if dif ();
		assign dif.hold = hold_v[g];
		assign dif.tick = tick_v[g];
		assign done_v[g] = dif.done;
		pmrs_rst_delay #(
			.COUNT(DLY_COUNT[g])
		) u_dly (
			.clk_i(ref_clk_i),
			.rst_n_i(g == PMRS_ST_XPOR ? reset_n_i : rst_any_n),
			.dl(dif)
		);
	end

	// Early resets on the rising edge
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tap_reset_n_o <= 1'b0;
			ext_por_reset_n_o <= 1'b0;
			sync_reset_n_o <= 1'b0;
		end else begin
			tap_reset_n_o <= por_ok;
			ext_por_reset_n_o <= done_v[PMRS_ST_XPOR];
			sync_reset_n_o <= done_v[PMRS_ST_SYNC] & combined_n;
		end
	end

	// Staged resets leave on the falling edge to avoid skew
	always_ff @(negedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			clock_generator_reset_n_o <= 1'b0;
			peripheral_reset_n_o <= 1'b0;
			core_reset_n_o <= 1'b0;
		end else begin
			clock_generator_reset_n_o <= done_v[PMRS_ST_CGEN];
			peripheral_reset_n_o <= done_v[PMRS_ST_PERI];
			core_reset_n_o <= done_v[PMRS_ST_CORE];
		end
	end

	// ==========================================================
	// Clock dividers

	logic [PMRS_WDOG_W-1:0] wd_div;

	// System clock rate is half the master clock
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			sys_tick <= 1'b0;
		end else begin
			sys_tick <= !sys_tick;
		end
	end

	// Watchdog time base, stopped in power-down
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			wd_div <= '0;
			watchdog_tick_o <= 1'b0;
		end else if (mode == PMRS_PDOWN) begin
			watchdog_tick_o <= 1'b0;
		end else begin
			wd_div <= wd_div + 1'b1;
			watchdog_tick_o <= (wd_div ==
				PMRS_WDOG_W'(PMRS_WDOG_DIV - 1));
		end
	end

	// ==========================================================
	// Software and watchdog reset requests

	logic wr_en;
	logic ctrl_hit;

	// Requests ignored while their logic is held or powered down
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			sw_req <= 1'b0;
			wd_req <= 1'b0;
		end else if (!sync_reset_n_o || mode == PMRS_PDOWN) begin
			sw_req <= 1'b0;
			wd_req <= 1'b0;
		end else begin
			sw_req <= ctrl_hit && wb_sel_i[0] &&
				wb_dat_i[PMRS_CTRL_SWRST];
			wd_req <= watchdog_timeout_reset_i |
				watchdog_lost_reference_reset_i;
		end
	end

	// ==========================================================
	// Wishbone register file

	logic [PMRS_CTRL_FAST+PMRS_FAST_W-1:1] ctrl;
	logic [NPERIPH-1:0] stop_dis;
	logic [4:0] cause;
	logic [4:0] cause_set;
	logic [31:0] status;
	logic [31:0] rd_data;
	logic standby;
	logic fast_ok;
	logic wd_ok;

	// Write strobe at the edge that ends the answer
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign ctrl_hit = wr_en && wb_adr_i == PMRS_CTRL_ADDR &&
		mode != PMRS_PDOWN;

	// One-wait-state answer; unmapped reads give zero
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
		end
	end

	// Control bits, cleared by the combined reset
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			ctrl <= '0;
		end else if (!combined_n) begin
			ctrl <= '0;
		end else if (ctrl_hit) begin
			if (wb_sel_i[0]) begin
				ctrl[7:1] <= wb_dat_i[7:1];
			end
			if (wb_sel_i[1]) begin
				ctrl[PMRS_CTRL_FAST+PMRS_FAST_W-1:8] <=
					wb_dat_i[PMRS_CTRL_FAST+PMRS_FAST_W-1:8];
			end
		end
	end

	// Per-peripheral stop disable bits
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			stop_dis <= '0;
		end else if (!combined_n) begin
			stop_dis <= '0;
		end else if (wr_en && wb_adr_i == PMRS_STOPDIS_ADDR) begin
			for (int b = 0; b < NPERIPH; b++) begin
				if (wb_sel_i[b/8]) begin
					stop_dis[b] <= wb_dat_i[b];
				end
			end
		end
	end

	// Reset cause events, caught as the request is accepted
	assign wd_ok = sync_reset_n_o & (mode != PMRS_PDOWN);
	assign cause_set = {watchdog_lost_reference_reset_i & wd_ok,
		watchdog_timeout_reset_i & wd_ok, sw_req, !ext_ok & por_ok,
		1'b0};

	// Sticky causes, write one to clear, set wins
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cause <= PMRS_CAUSE_RST;
		end else if (wr_en && wb_adr_i == PMRS_CAUSE_ADDR &&
			wb_sel_i[0]) begin
			cause <= (cause & ~wb_dat_i[4:0]) | cause_set;
		end else begin
			cause <= cause | cause_set;
		end
	end

	// Standby set-up and triple-rate availability
	assign standby = ctrl[PMRS_CTRL_SRCSEL] & ctrl[PMRS_CTRL_PLL_POWER_DOWN] &
		ctrl[PMRS_CTRL_ROSTBY];
	assign fast_ok = !ctrl[PMRS_CTRL_SRCSEL] &
		!ctrl[PMRS_CTRL_PLL_POWER_DOWN];

	// Status word
	assign status = {25'h0000000, core_reset_n_o, peripheral_reset_n_o,
		clock_generator_reset_n_o, fast_ok, standby, mode};

	// Read multiplexer
	always_comb begin
		unique case (wb_adr_i)
			PMRS_CTRL_ADDR: rd_data = 32'(ctrl) << 1;
			PMRS_STOPDIS_ADDR: rd_data = 32'(stop_dis);
			PMRS_STATUS_ADDR: rd_data = status;
			PMRS_CAUSE_ADDR: rd_data = 32'(cause);
			default: rd_data = 32'h00000000;
		endcase
	end

	// Read data registered with the answer
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= rd_data;
		end
	end

	// ==========================================================
	// Power mode state machine

	pmrs_mode_e next_mode;
	logic stop_wake;

	// Wake from Stop by peripherals kept running, low-voltage or debug
	assign stop_wake = |(periph_irq_i & stop_dis) | low_voltage_irq_i |
		debug_entry_i;

	// Next mode
	always_comb begin
		next_mode = mode;
		unique case (mode)
			PMRS_RUN: begin
				if (standby && ctrl[PMRS_CTRL_RELAX_OSC_POWER_DOWN]) begin
					next_mode = PMRS_PDOWN;
				end else if (core_stop_i) begin
					next_mode = PMRS_STOP;
				end else if (core_wait_i) begin
					next_mode = PMRS_WAIT;
				end
			end
			PMRS_WAIT: begin
				if (any_irq_i || debug_entry_i) begin
					next_mode = PMRS_RUN;
				end
			end
			PMRS_STOP: begin
				if (stop_wake) begin
					next_mode = PMRS_RUN;
				end
			end
			PMRS_PDOWN: next_mode = PMRS_PDOWN;
		endcase
	end

	// Any reset returns to Run; power-down needs external/power-on
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			mode <= PMRS_RUN;
		end else if (!combined_n && mode != PMRS_PDOWN) begin
			mode <= PMRS_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	// ==========================================================
	// Clock gating outputs

	logic run_ok;

	assign run_ok = clock_generator_reset_n_o;

	// Group gates per mode, enabled by default after reset
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			sys_tick_o <= 1'b0;
			sysclk_gen_en_o <= 1'b1;
			core_clk_en_o <= 1'b1;
			mem_clk_en_o <= 1'b1;
		end else begin
			sys_tick_o <= sys_tick & run_ok & mode != PMRS_PDOWN;
			sysclk_gen_en_o <= mode == PMRS_RUN ||
				mode == PMRS_WAIT;
			core_clk_en_o <= mode == PMRS_RUN;
			mem_clk_en_o <= mode == PMRS_RUN;
		end
	end

	// Peripheral gates with stop-disable override
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			periph_clk_en_o <= '1;
			fast_clk_en_o <= '0;
		end else begin
			for (int p = 0; p < NPERIPH; p++) begin
				periph_clk_en_o[p] <= mode == PMRS_RUN ||
					mode == PMRS_WAIT ||
					(mode == PMRS_STOP && stop_dis[p]);
			end
			for (int f = 0; f < PMRS_FAST_W; f++) begin
				fast_clk_en_o[f] <= ctrl[PMRS_CTRL_FAST+f] & fast_ok &
					(mode == PMRS_RUN || mode == PMRS_WAIT ||
					(mode == PMRS_STOP && stop_dis[f]));
			end
		end
	end

	// Clock generator controls from the control register
	always_ff @(posedge ref_clk_i or negedge rst_any_n) begin
		if (!rst_any_n) begin
			clock_source_select_o <= 1'b0;
			pll_power_down_o <= 1'b0;
			relax_osc_standby_o <= 1'b0;
			large_regulator_standby_o <= 1'b0;
			relax_osc_power_down_o <= 1'b0;
		end else begin
			clock_source_select_o <= ctrl[PMRS_CTRL_SRCSEL];
			pll_power_down_o <= ctrl[PMRS_CTRL_PLL_POWER_DOWN];
			relax_osc_standby_o <= ctrl[PMRS_CTRL_ROSTBY];
			large_regulator_standby_o <= ctrl[PMRS_CTRL_LRSTBY];
			relax_osc_power_down_o <= ctrl[PMRS_CTRL_RELAX_OSC_POWER_DOWN];
		end
	end

endmodule

// ### hw/pmrs_pkg.sv
package pmrs_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] PMRS_CTRL_ADDR = 8'h00;
	localparam logic [7:0] PMRS_STOPDIS_ADDR = 8'h04;
	localparam logic [7:0] PMRS_STATUS_ADDR = 8'h08;
	localparam logic [7:0] PMRS_CAUSE_ADDR = 8'h0C;

	// ==========================================================
	// Control register fields
	localparam int PMRS_CTRL_SWRST = 0;
	localparam int PMRS_CTRL_SRCSEL = 1;
	localparam int PMRS_CTRL_PLL_POWER_DOWN = 2;
	localparam int PMRS_CTRL_ROSTBY = 3;
	localparam int PMRS_CTRL_LRSTBY = 4;
	localparam int PMRS_CTRL_RELAX_OSC_POWER_DOWN = 5;
	localparam int PMRS_CTRL_FAST = 8;
	localparam int PMRS_FAST_W = 3;

	// Triple-rate capable peripherals: PWM, timer, I2C
	localparam int PMRS_PERIPH_PWM = 0;
	localparam int PMRS_PERIPH_TMR = 1;
	localparam int PMRS_PERIPH_I2C = 2;

	// Cause register fields
	localparam int PMRS_CAUSE_POR = 0;
	localparam int PMRS_CAUSE_EXT = 1;
	localparam int PMRS_CAUSE_SW = 2;
	localparam int PMRS_CAUSE_WDTO = 3;
	localparam int PMRS_CAUSE_WDLR = 4;
	localparam logic [4:0] PMRS_CAUSE_RST = 5'h01;

	// ==========================================================
	// Reset release stages and their counts
	localparam int PMRS_STAGES = 5;
	localparam int PMRS_ST_XPOR = 0;
	localparam int PMRS_ST_SYNC = 1;
	localparam int PMRS_ST_CGEN = 2;
	localparam int PMRS_ST_PERI = 3;
	localparam int PMRS_ST_CORE = 4;
	localparam int PMRS_XPOR_CYC = 64;
	localparam int PMRS_SYNC_CYC = 3;
	localparam int PMRS_CGEN_CYC = 32;
	localparam int PMRS_PERI_CYC = 32;
	localparam int PMRS_CORE_CYC = 32;
	localparam int PMRS_DLY_W = 7;

	// Watchdog clock divide ratio on the oscillator clock
	localparam int PMRS_WDOG_DIV = 1024;
	localparam int PMRS_WDOG_W = 10;

	// ==========================================================
	// Power mode state
	typedef enum logic [1:0] {
		PMRS_RUN = 2'b00,
		PMRS_WAIT = 2'b01,
		PMRS_STOP = 2'b10,
		PMRS_PDOWN = 2'b11
	} pmrs_mode_e;

endpackage

// ### hw/pmrs_dly_if.sv
`timescale 1ns/1ns
// Control and status of one reset release stage
interface pmrs_dly_if;
	logic hold;
	logic tick;
	logic done;
	modport ctrl (output hold, output tick, input done);
	modport stage (input hold, input tick, output done);
endinterface

// ### hw/pmrs_rst_delay.sv
`timescale 1ns/1ns
module pmrs_rst_delay
	import pmrs_pkg::*;
#(
	parameter int COUNT = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Stage control
	pmrs_dly_if.stage dl
);

	logic [PMRS_DLY_W-1:0] cnt;

	// ==========================================================
	// Count ticks after hold drops, then release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= '0;
			dl.done <= 1'b0;
		end else if (dl.hold) begin
			cnt <= '0;
			dl.done <= 1'b0;
		end else if (!dl.done && dl.tick) begin
			if (cnt == PMRS_DLY_W'(COUNT - 1)) begin
				dl.done <= 1'b1;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

endmodule

// ### verification/pmrs_core_model.sv
`timescale 1ns/1ns
// ====================
// Core and interrupt sources facing the block
module pmrs_core_model (
	// Clock and core reset
	input wire logic ref_clk_i,
	input wire logic core_reset_n_i,
	// Instructions and debug command
	output logic core_wait_o,
	output logic core_stop_o,
	output logic debug_entry_o,
	// Interrupt levels
	output logic any_irq_o,
	output logic low_voltage_irq_o,
	output logic [7:0] periph_irq_o
);
	// Quiet at start
	initial begin
		{core_wait_o, core_stop_o, debug_entry_o} = 3'h0;
		{any_irq_o, low_voltage_irq_o, periph_irq_o} = 10'h000;
	end
	// One-cycle pulse: 0 wait, 1 stop, else debug; core must run
	task pulse(input int k);
		int t;
		t = 0;
		while (core_reset_n_i !== 1'h1 && t < 500) begin
			@(posedge ref_clk_i);
			t++;
		end
		@(posedge ref_clk_i);
		case (k)
			0: core_wait_o <= 1'h1;
			1: core_stop_o <= 1'h1;
			default: debug_entry_o <= 1'h1;
		endcase
		@(posedge ref_clk_i);
		{core_wait_o, core_stop_o, debug_entry_o} <= 3'h0;
	endtask
	// Interrupt levels held until changed
	task level(input logic a, input logic v, input logic [7:0] p);
		@(posedge ref_clk_i);
		{any_irq_o, low_voltage_irq_o, periph_irq_o} <= {a, v, p};
	endtask
endmodule

// ### verification/pmrs_top_props.sv
`timescale 1ns/1ns
// ====================
// Port checker for the sequencer
module pmrs_top_props
	import pmrs_pkg::*;
#(
	parameter int NPERIPH = 8
) (
	// Clock, resets and events
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic ext_reset_n_i,
	input wire logic core_wait_i,
	input wire logic core_stop_i,
	input wire logic debug_entry_i,
	input wire logic any_irq_i,
	input wire logic low_voltage_irq_i,
	// Gating and controls
	input wire logic watchdog_tick_o,
	input wire logic sysclk_gen_en_o,
	input wire logic core_clk_en_o,
	input wire logic mem_clk_en_o,
	input wire logic [NPERIPH-1:0] periph_clk_en_o,
	input wire logic [PMRS_FAST_W-1:0] fast_clk_en_o,
	input wire logic clock_source_select_o,
	input wire logic pll_power_down_o,
	input wire logic relax_osc_standby_o,
	input wire logic relax_osc_power_down_o,
	// Staged resets
	input wire logic tap_reset_n_o,
	input wire logic ext_por_reset_n_o,
	input wire logic clock_generator_reset_n_o,
	input wire logic peripheral_reset_n_o,
	input wire logic core_reset_n_o
);
	logic [7:0] cg_cnt;
	logic [7:0] pe_cnt;
	logic [7:0] co_cnt;
	logic [9:0] wd_cnt;
	logic wd_seen;
	logic pdown;

	// ====================
	// Stage length counters
	always_ff @(posedge ref_clk_i) begin
		if (!ext_reset_n_i || !ext_por_reset_n_o || clock_generator_reset_n_o)
			cg_cnt <= 8'h00;
		else
			cg_cnt <= cg_cnt + 8'h01;
	end
	always_ff @(posedge ref_clk_i) begin
		pe_cnt <= (!clock_generator_reset_n_o || peripheral_reset_n_o) ?
			8'h00 : pe_cnt + 8'h01;
	end
	always_ff @(posedge ref_clk_i) begin
		co_cnt <= (!peripheral_reset_n_o || core_reset_n_o) ?
			8'h00 : co_cnt + 8'h01;
	end
	// Spacing of watchdog ticks
	always_ff @(posedge ref_clk_i) begin
		wd_cnt <= (!clock_generator_reset_n_o || watchdog_tick_o) ?
			10'h000 : wd_cnt + 10'h001;
		wd_seen <= clock_generator_reset_n_o && (wd_seen || watchdog_tick_o);
	end
	// Power-down configuration seen while stopped
	assign pdown = !sysclk_gen_en_o && relax_osc_power_down_o &&
		clock_source_select_o && pll_power_down_o && relax_osc_standby_o;

	// ====================
	// Assertions
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i || !ext_reset_n_i);

	core_mem_pair_a: assert property (core_clk_en_o == mem_clk_en_o)
		else $error("core and memory gates differ");
	wait_entry_a: assert property (core_wait_i && !core_stop_i &&
		!debug_entry_i && core_clk_en_o && core_reset_n_o |-> ##2
		!core_clk_en_o && sysclk_gen_en_o && &periph_clk_en_o)
		else $error("wait gating wrong");
	wait_wake_a: assert property (sysclk_gen_en_o && !core_clk_en_o &&
		(any_irq_i || debug_entry_i) |-> ##[1:2] core_clk_en_o)
		else $error("no wake from wait");
	stop_entry_a: assert property (core_stop_i && !debug_entry_i &&
		core_clk_en_o && core_reset_n_o |-> ##2
		!sysclk_gen_en_o && !core_clk_en_o)
		else $error("stop gating wrong");
	stop_wake_a: assert property (!sysclk_gen_en_o &&
		!relax_osc_power_down_o && (low_voltage_irq_i || debug_entry_i)
		|-> ##[1:2] sysclk_gen_en_o)
		else $error("no wake from stop");
	pdown_hold_a: assert property (pdown |=> !sysclk_gen_en_o &&
		!core_clk_en_o && periph_clk_en_o == '0)
		else $error("power-down left or gates on");
	fast_off_a: assert property ((clock_source_select_o ||
		pll_power_down_o) [*2] |-> fast_clk_en_o == '0)
		else $error("fast clock without pll");
	tap_hold_a: assert property (disable iff (!reset_n_i)
		tap_reset_n_o |=> tap_reset_n_o)
		else $error("test port reset by other source");
	xpor_cgen_a: assert property (!ext_por_reset_n_o |->
		!clock_generator_reset_n_o)
		else $error("clock-gen free during extended por");
	cgen_rel_a: assert property ($rose(clock_generator_reset_n_o)
		|-> cg_cnt inside {[32:37]})
		else $error("clock-gen release count wrong");
	peri_rel_a: assert property ($rose(peripheral_reset_n_o)
		|-> pe_cnt inside {[63:65]})
		else $error("peripheral release count wrong");
	core_rel_a: assert property ($rose(core_reset_n_o)
		|-> co_cnt inside {[63:65]})
		else $error("core release count wrong");
	wdog_div_a: assert property (watchdog_tick_o && wd_seen |->
		wd_cnt == 10'h3FF)
		else $error("watchdog tick spacing wrong");
endmodule

bind pmrs_top pmrs_top_props #(.NPERIPH(NPERIPH)) i_props (.*);

// ### verification/pmrs_top_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	$display("Error %s expected %0h seen %0h", nm, e, g); errors++; end end
// ====================
// Self-checking bench for the sequencer
module pmrs_top_test;
	import pmrs_pkg::*;
	logic ref_clk_i, reset_n_i, ext_reset_n_i;
	logic watchdog_timeout_reset_i, watchdog_lost_reference_reset_i;
	logic core_wait_i, core_stop_i, debug_entry_i;
	logic any_irq_i, low_voltage_irq_i;
	logic [7:0] periph_irq_i, wb_adr_i, periph_clk_en_o;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_sel_i, sel;
	logic [10:0] gates;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic sys_tick_o, watchdog_tick_o, sysclk_gen_en_o;
	logic core_clk_en_o, mem_clk_en_o;
	logic [2:0] fast_clk_en_o;
	logic clock_source_select_o, pll_power_down_o, relax_osc_standby_o;
	logic large_regulator_standby_o, relax_osc_power_down_o;
	logic tap_reset_n_o, ext_por_reset_n_o, sync_reset_n_o;
	logic clock_generator_reset_n_o, peripheral_reset_n_o, core_reset_n_o;
	int errors, total_checks, cycles, n, ticks, sys;

	pmrs_top i_dut (.*);
	pmrs_core_model i_core (.ref_clk_i(ref_clk_i),
		.core_reset_n_i(core_reset_n_o), .core_wait_o(core_wait_i),
		.core_stop_o(core_stop_i), .debug_entry_o(debug_entry_i),
		.any_irq_o(any_irq_i), .low_voltage_irq_o(low_voltage_irq_i),
		.periph_irq_o(periph_irq_i));
	assign gates = {sysclk_gen_en_o, core_clk_en_o, mem_clk_en_o,
		periph_clk_en_o};

	// ====================
	// Clock and hang guard
	initial begin
		ref_clk_i = 1'h0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		cycles = 0;
		forever begin
			@(posedge ref_clk_i);
			cycles++;
			if (cycles > 20000) begin
				errors++;
				stop_test();
			end
		end
	end
	// Verdict and end of run
	task stop_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Wait whole cycles, then look past the edge
	task step(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	// One classic bus cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge ref_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <=
			{2'h3, w, a, d, sel};
		t = 0;
		do begin
			@(posedge ref_clk_i);
			t++;
		end while (wb_ack_o !== 1'h1 && t < 20);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (t >= 20) errors++;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'h0, a, 32'h0);
		`CHK(nm, e, rd);
	endtask
	// Bounded wait for the core to start
	task boot();
		int t;
		t = 0;
		while (core_reset_n_o !== 1'h1 && t < 400) begin
			step(1);
			t++;
		end
		`CHK("core reset", 1'h1, core_reset_n_o);
	endtask

	// ====================
	// Test sequence
	initial begin
		{errors, total_checks} = 0;
		{reset_n_i, ext_reset_n_i, sel} = 6'h1F;
		reset_n_i = 1'h0;
		{watchdog_timeout_reset_i, watchdog_lost_reference_reset_i} = 2'h0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = 47'h0;
		repeat (8) @(posedge ref_clk_i);
		reset_n_i <= 1'h1;
		boot();
		`CHK("gates", 11'h7FF, gates);
		rchk(PMRS_CAUSE_ADDR, 32'h01, "cause");
		rchk(PMRS_STATUS_ADDR, 32'h78, "status");
		rchk(8'h10, 32'h0, "unmapped");
		$display("reset test done");
		// Wait entry and exits
		i_core.pulse(0);
		step(2);
		`CHK("wait", 11'h4FF, gates);
		i_core.level(1'h1, 1'h0, 8'h00);
		step(3);
		`CHK("irq wake", 1'h1, core_clk_en_o);
		i_core.level(1'h0, 1'h0, 8'h00);
		i_core.pulse(0);
		i_core.pulse(2);
		step(3);
		`CHK("debug wake", 1'h1, core_clk_en_o);
		$display("wait test done");
		// Stop with two peripherals kept running
		wb(1'h1, PMRS_STOPDIS_ADDR, 32'h05);
		for (n = 0; n < 3; n++) begin
			i_core.pulse(1);
			step(2);
			`CHK("stop", 11'h005, gates);
			rchk(PMRS_STATUS_ADDR, 32'h7A, "stop status");
			i_core.level(1'h0, 1'h0, 8'h02);
			step(3);
			`CHK("no wake", 1'h0, sysclk_gen_en_o);
			i_core.level(1'h0, n == 0, n == 1 ? 8'h04 : 8'h00);
			if (n == 2) i_core.pulse(2);
			step(3);
			`CHK("stop wake", 1'h1, sysclk_gen_en_o);
			i_core.level(1'h0, 1'h0, 8'h00);
		end
		$display("stop test done");
		// Fast bits refused on lane 0 alone, then taken; then standby
		sel = 4'h1;
		wb(1'h1, PMRS_CTRL_ADDR, 32'h700);
		step(2);
		`CHK("sel lane", 3'h0, fast_clk_en_o);
		sel = 4'hF;
		wb(1'h1, PMRS_CTRL_ADDR, 32'h700);
		step(2);
		`CHK("fast", 3'h7, fast_clk_en_o);
		for (n = 1; n < 5; n++)
			wb(1'h1, PMRS_CTRL_ADDR, 32'h700 | ((1 << (n + 1)) - 2));
		step(2);
		`CHK("no fast", 3'h0, fast_clk_en_o);
		`CHK("standby", 4'hF, {large_regulator_standby_o, relax_osc_standby_o, pll_power_down_o, clock_source_select_o});
		rchk(PMRS_STATUS_ADDR, 32'h74, "standby status");
		i_core.pulse(0);
		step(2);
		`CHK("standby wait", 1'h0, core_clk_en_o);
		i_core.pulse(2);
		// Power-down kept through interrupt, debug and software reset; left by the external pin
		wb(1'h1, PMRS_CTRL_ADDR, 32'h73E);
		step(2);
		`CHK("pdown", 11'h000, gates);
		i_core.level(1'h1, 1'h1, 8'hFF);
		i_core.pulse(2);
		wb(1'h1, PMRS_CTRL_ADDR, 32'h1);
		step(4);
		`CHK("pdown stays", 2'h1, {sysclk_gen_en_o, clock_generator_reset_n_o});
		i_core.level(1'h0, 1'h0, 8'h00);
		ext_reset_n_i <= 1'h0;
		step(4);
		`CHK("ext reset", 4'hC, {tap_reset_n_o, ext_por_reset_n_o,
			sync_reset_n_o, clock_generator_reset_n_o});
		@(posedge ref_clk_i);
		ext_reset_n_i <= 1'h1;
		boot();
		`CHK("gates", 11'h7FF, gates);
		rchk(PMRS_CAUSE_ADDR, 32'h03, "ext cause");
		$display("power-down test done");
		// Synchronous sources: software, time-out, lost reference
		for (n = 0; n < 3; n++) begin
			wb(1'h1, PMRS_CAUSE_ADDR, 32'h1F);
			if (n == 0) wb(1'h1, PMRS_CTRL_ADDR, 32'h1);
			else begin
				@(posedge ref_clk_i);
				{watchdog_lost_reference_reset_i, watchdog_timeout_reset_i} <= n[1:0];
				@(posedge ref_clk_i);
				{watchdog_lost_reference_reset_i, watchdog_timeout_reset_i} <= 2'h0;
			end
			step(4);
			`CHK("staged low", 2'h0, {clock_generator_reset_n_o, core_reset_n_o});
			boot();
			rchk(PMRS_CAUSE_ADDR, 32'h4 << n, "sync cause");
		end
		$display("sync reset test done");
		// Watchdog and system tick rates in Run
		{ticks, sys} = 0;
		repeat (3072) begin
			@(posedge ref_clk_i);
			if (watchdog_tick_o === 1'h1) ticks++;
			if (sys_tick_o === 1'h1) sys++;
		end
		`CHK("wdog ticks", 3, ticks);
		`CHK("sys ticks", 1536, sys);
		$display("tick test done");
		stop_test();
	end
endmodule
